// *** inc/vcsr_defs.svh ***
// Constants of the valve current set-point ramp block
`ifndef VCSR_DEFS_SVH
`define VCSR_DEFS_SVH

// Register byte offsets
`define VCSR_OFF_CTRL       8'h00
`define VCSR_OFF_POT_MIN    8'h04
`define VCSR_OFF_POT_MAX    8'h08
`define VCSR_OFF_CUR_MIN    8'h0c
`define VCSR_OFF_CUR_MAX    8'h10
`define VCSR_OFF_RISE       8'h14
`define VCSR_OFF_FALL       8'h18
`define VCSR_OFF_STATUS     8'h1c

// Control and status field positions
`define VCSR_CTRL_MODE_BIT  0
`define VCSR_CTRL_EN_BIT    1
`define VCSR_STAT_REQ_BIT   16
`define VCSR_STAT_RAMP_BIT  17
`define VCSR_STAT_JUMP_BIT  18

// Reset values
`define VCSR_RST_POT_MIN    12'h100
`define VCSR_RST_POT_MAX    12'he00
`define VCSR_RST_CUR_MIN    16'h0100
`define VCSR_RST_CUR_MAX    16'h0800
`define VCSR_RST_RISE       16'h0064
`define VCSR_RST_FALL       16'h0064

// Timing: ramp tick period and clock period, in ns
`define VCSR_TICK_NS        10000
`define VCSR_CLK_NS         10

// AHB transfer type bit that marks NONSEQ or SEQ
`define VCSR_HTRANS_ACT_BIT 1

`endif

// *** inc/vcsr_pkg.sv ***
// Types of the valve current set-point ramp block
package vcsr_pkg;

  typedef enum logic {
    VCSR_MODE_PROP,
    VCSR_MODE_ONOFF
  } vcsr_mode_type;

endpackage : vcsr_pkg

// *** core/vcsr_target.sv ***
// Target current from pot voltage, lowering request and drive mode
module vcsr_target #(
  parameter int WP = 12,
  parameter int WI = 16
) (
  input  wire logic                  enable,
  input  wire vcsr_pkg::vcsr_mode_type mode,
  input  wire logic                  lower_req,
  input  wire logic [WP-1:0]         pot,
  input  wire logic [WP-1:0]         pot_min,
  input  wire logic [WP-1:0]         pot_max,
  input  wire logic [WI-1:0]         cur_min,
  input  wire logic [WI-1:0]         cur_max,
  output logic      [WI-1:0]         target
);

  logic [WP-1:0]    pot_off;
  logic [WP-1:0]    pot_span;
  logic [WI-1:0]    cur_span;
  logic [WP+WI-1:0] prod;
  logic [WP+WI-1:0] quot;

  assign pot_off  = WP'(pot - pot_min);
  assign pot_span = WP'(pot_max - pot_min);
  assign cur_span = (cur_max > cur_min) ? WI'(cur_max - cur_min) : '0;
  assign prod     = (WP+WI)'(pot_off) * (WP+WI)'(cur_span);
  assign quot     = (pot_span == '0) ? '0 : prod / (WP+WI)'(pot_span);

  always_comb begin
    target = '0;
    if (!enable) begin
      target = '0;
    end else if (mode == vcsr_pkg::VCSR_MODE_ONOFF) begin
      target = lower_req ? cur_max : '0; // [R04] [R10] [R11]
    end else if (pot < pot_min) begin
      target = '0; // [R03]
    end else if (pot >= pot_max) begin
      target = cur_max; // [R12]
    end else begin
      target = WI'(cur_min + WI'(quot)); // [R02]
    end
  end

endmodule : vcsr_target

// *** core/vcsr_ramp.sv ***
// Next set-point value under rise and fall slope limits
module vcsr_ramp #(
  parameter int WI = 16,
  parameter int WT = 16
) (
  input  wire logic                  tick,
  input  wire vcsr_pkg::vcsr_mode_type mode,
  input  wire logic [WI-1:0]         value,
  input  wire logic [WI-1:0]         target,
  input  wire logic [WI-1:0]         floor_cur,
  input  wire logic [WI-1:0]         span,
  input  wire logic [WT-1:0]         rise_ticks,
  input  wire logic [WT-1:0]         fall_ticks,
  output logic      [WI-1:0]         step_up,
  output logic      [WI-1:0]         step_dn,
  output logic                       jump,
  output logic      [WI-1:0]         value_d
);

  logic          prop;
  logic [WI-1:0] goal;
  logic [WI:0]   up_sum;
  logic [WI-1:0] q_up;
  logic [WI-1:0] q_dn;

  assign prop = (mode == vcsr_pkg::VCSR_MODE_PROP);
  // Proportional release ramps to the minimum first
  assign goal = (prop && target == '0) ? floor_cur : target; // [R09]

  // Fixed increment: span over ticks, at least one
  assign q_up    = (rise_ticks == '0) ? span : WI'(span / WI'(rise_ticks));
  assign q_dn    = (fall_ticks == '0) ? span : WI'(span / WI'(fall_ticks));
  assign step_up = (q_up == '0) ? WI'(1) : q_up; // [R13] [R06]
  assign step_dn = (q_dn == '0) ? WI'(1) : q_dn; // [R13] [R07]
  assign up_sum  = {1'b0, value} + {1'b0, step_up};
  assign jump    = prop && target != '0 && value < floor_cur; // [R08]

  always_comb begin
    value_d = value;
    if (jump) begin
      value_d = (floor_cur < target) ? floor_cur : target; // [R08]
    end else if (prop && target == '0 && value <= floor_cur) begin
      value_d = '0; // [R09]
    end else if (tick) begin
      if (value < goal) begin
        if (up_sum > {1'b0, goal}) begin
          value_d = goal; // [R13]
        end else begin
          value_d = WI'(up_sum); // [R05] [R06]
        end
      end else if (value > goal) begin
        if (WI'(value - goal) < step_dn) begin
          value_d = goal; // [R13]
        end else begin
          value_d = WI'(value - step_dn); // [R05] [R07]
        end
      end
    end
  end

endmodule : vcsr_ramp

// *** core/vcsr_top.sv ***
// Lowering valve current set-point generator with AHB-Lite registers
//
// Contract
// [R01] Proportional and on/off valve drive modes
// [R02] Proportional: linear voltage-to-current map between limits
// [R03] Proportional: zero below minimum pot voltage
// [R04] On/off: only maximum current sets the target
// [R05] Every set-point change is rate limited; the R08 jump and the R09 drop to zero happen at once, not per tick
// [R06] Zero-to-max rise lasts the rise time
// [R07] Max-to-zero fall lasts the fall time
// [R08] Proportional step: jump to minimum, then ramp
// [R09] Proportional release: ramp to minimum, then zero
// [R10] On/off request: ramp zero to maximum
// [R11] On/off release: ramp linearly down to zero
// [R12] Proportional: saturate at maximum above max voltage
// [R13] Fixed per-tick increment, clamped at target
`include "vcsr_defs.svh"

module vcsr_top #(
  parameter int WP          = 12,
  parameter int WI          = 16,
  parameter int WT          = 16,
  parameter int TICK_CYCLES =
    (`VCSR_TICK_NS + `VCSR_CLK_NS - 1) / `VCSR_CLK_NS
) (
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire logic          ce,
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic      [31:0]   hrdata,
  output logic               hreadyout,
  output logic               hresp,
  input  wire logic [WP-1:0] pot_voltage,
  input  wire logic          lower_req,
  output logic      [WI-1:0] valve_setpoint,
  output logic               valve_active
);

  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [WP-1:0] pot_m_q;
  logic [WP-1:0] pot_s_q;
  logic          req_m_q;
  logic          req_s_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pot_m_q <= '0;
      pot_s_q <= '0;
      req_m_q <= 1'b0;
      req_s_q <= 1'b0;
    end else if (ce) begin
      pot_m_q <= pot_voltage;
      pot_s_q <= pot_m_q;
      req_m_q <= lower_req;
      req_s_q <= req_m_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave, one wait state per transfer

  logic                    pend_q;
  logic                    pend_wr_q;
  logic [7:0]              pend_addr_q;
  logic                    hready_q;
  logic [31:0]             hrdata_q;
  logic                    take;
  vcsr_pkg::vcsr_mode_type mode_q;
  logic                    en_q;
  logic [WP-1:0]           pot_min_q;
  logic [WP-1:0]           pot_max_q;
  logic [WI-1:0]           cur_min_q;
  logic [WI-1:0]           cur_max_q;
  logic [WT-1:0]           rise_q;
  logic [WT-1:0]           fall_q;
  logic [WI-1:0]           setpoint_q;
  logic                    active_q;
  logic                    ramping;
  logic                    jump;
  logic [31:0]             rd_word;

  assign take = hsel && hready && htrans[`VCSR_HTRANS_ACT_BIT];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_q      <= 1'b0;
      pend_wr_q   <= 1'b0;
      pend_addr_q <= '0;
      hready_q    <= 1'b1;
    end else if (ce) begin
      if (take) begin
        pend_q      <= 1'b1;
        pend_wr_q   <= hwrite;
        pend_addr_q <= haddr[7:0];
        hready_q    <= 1'b0;
      end else begin
        pend_q   <= 1'b0;
        hready_q <= 1'b1;
      end
    end
  end

  // Configuration writes in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q    <= vcsr_pkg::VCSR_MODE_PROP;
      en_q      <= 1'b0;
      pot_min_q <= `VCSR_RST_POT_MIN;
      pot_max_q <= `VCSR_RST_POT_MAX;
      cur_min_q <= `VCSR_RST_CUR_MIN;
      cur_max_q <= `VCSR_RST_CUR_MAX;
      rise_q    <= `VCSR_RST_RISE;
      fall_q    <= `VCSR_RST_FALL;
    end else if (ce && pend_q && pend_wr_q) begin
      case (pend_addr_q)
        `VCSR_OFF_CTRL: begin
          mode_q <= vcsr_pkg::vcsr_mode_type'(
                      hwdata[`VCSR_CTRL_MODE_BIT]); // [R01]
          en_q   <= hwdata[`VCSR_CTRL_EN_BIT];
        end
        `VCSR_OFF_POT_MIN: pot_min_q <= hwdata[WP-1:0];
        `VCSR_OFF_POT_MAX: pot_max_q <= hwdata[WP-1:0];
        `VCSR_OFF_CUR_MIN: cur_min_q <= hwdata[WI-1:0];
        `VCSR_OFF_CUR_MAX: cur_max_q <= hwdata[WI-1:0];
        `VCSR_OFF_RISE:    rise_q    <= hwdata[WT-1:0];
        `VCSR_OFF_FALL:    fall_q    <= hwdata[WT-1:0];
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    rd_word = '0;
    case (pend_addr_q)
      `VCSR_OFF_CTRL: begin
        rd_word[`VCSR_CTRL_MODE_BIT] = (mode_q == vcsr_pkg::VCSR_MODE_ONOFF);
        rd_word[`VCSR_CTRL_EN_BIT]   = en_q;
      end
      `VCSR_OFF_POT_MIN: rd_word[WP-1:0] = pot_min_q;
      `VCSR_OFF_POT_MAX: rd_word[WP-1:0] = pot_max_q;
      `VCSR_OFF_CUR_MIN: rd_word[WI-1:0] = cur_min_q;
      `VCSR_OFF_CUR_MAX: rd_word[WI-1:0] = cur_max_q;
      `VCSR_OFF_RISE:    rd_word[WT-1:0] = rise_q;
      `VCSR_OFF_FALL:    rd_word[WT-1:0] = fall_q;
      `VCSR_OFF_STATUS: begin
        rd_word[WI-1:0]             = setpoint_q;
        rd_word[`VCSR_STAT_REQ_BIT]  = active_q;
        rd_word[`VCSR_STAT_RAMP_BIT] = ramping;
        rd_word[`VCSR_STAT_JUMP_BIT] = jump;
      end
      default: rd_word = '0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= '0;
    end else if (ce && pend_q && !pend_wr_q) begin
      hrdata_q <= rd_word;
    end
  end

  assign hrdata    = hrdata_q;
  assign hreadyout = hready_q;
  assign hresp     = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Ramp tick generator

  logic [TW-1:0] tick_cnt_q;
  logic          tick_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end else if (ce) begin
      tick_q <= (tick_cnt_q == TICK_LAST);
      if (tick_cnt_q == TICK_LAST) begin
        tick_cnt_q <= '0;
      end else begin
        tick_cnt_q <= TW'(tick_cnt_q + TW'(1));
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Target and ramp

  logic [WI-1:0] target;
  logic [WI-1:0] span;
  logic [WI-1:0] step_up;
  logic [WI-1:0] step_dn;
  logic [WI-1:0] value_d;

  // Full scale: min-to-max in proportional, zero-to-max in on/off
  assign span = (mode_q == vcsr_pkg::VCSR_MODE_ONOFF) ? cur_max_q :
                (cur_max_q > cur_min_q) ? WI'(cur_max_q - cur_min_q) :
                WI'(1);

  vcsr_target #(
    .WP (WP),
    .WI (WI)
  ) u_target (
    .enable    (en_q),
    .mode      (mode_q),
    .lower_req (req_s_q),
    .pot       (pot_s_q),
    .pot_min   (pot_min_q),
    .pot_max   (pot_max_q),
    .cur_min   (cur_min_q),
    .cur_max   (cur_max_q),
    .target    (target)
  );

  vcsr_ramp #(
    .WI (WI),
    .WT (WT)
  ) u_ramp (
    .tick       (tick_q),
    .mode       (mode_q),
    .value      (setpoint_q),
    .target     (target),
    .floor_cur  (cur_min_q),
    .span       (span),
    .rise_ticks (rise_q),
    .fall_ticks (fall_q),
    .step_up    (step_up),
    .step_dn    (step_dn),
    .jump       (jump),
    .value_d    (value_d)
  );

  assign ramping = (setpoint_q != target);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      setpoint_q <= '0;
      active_q   <= 1'b0;
    end else if (ce) begin
      setpoint_q <= value_d; // [R05]
      active_q   <= (target != '0);
    end
  end

  assign valve_setpoint = setpoint_q;
  assign valve_active   = active_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  logic prop;
  assign prop = (mode_q == vcsr_pkg::VCSR_MODE_PROP);

  a_below_min_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    prop && en_q && pot_s_q < pot_min_q |-> target == '0) // [R03]
    else $error("target not zero below minimum voltage");

  a_sat_at_max: assert property (@(posedge hclk) disable iff (!hresetn)
    prop && en_q && pot_s_q >= pot_max_q && pot_s_q >= pot_min_q
    |-> target == cur_max_q) // [R12]
    else $error("target not saturated at maximum");

  a_onoff_target: assert property (@(posedge hclk) disable iff (!hresetn)
    !prop && en_q |-> target == (req_s_q ? cur_max_q : '0)) // [R04]
    else $error("on/off target not from maximum current");

  a_prop_jump_min: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && prop && target >= cur_min_q && target != '0 &&
    setpoint_q < cur_min_q |=> setpoint_q == $past(cur_min_q)) // [R08]
    else $error("set-point did not jump to minimum");

  a_prop_zero_end: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && prop && target == '0 && setpoint_q <= cur_min_q
    |=> setpoint_q == '0) // [R09]
    else $error("set-point not forced to zero after ramp");

  a_onoff_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && !prop && !tick_q |=> $stable(setpoint_q)) // [R05]
    else $error("set-point moved without a tick");

  a_rise_step: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && tick_q && !jump && setpoint_q < target
    |=> setpoint_q > $past(setpoint_q) &&
        setpoint_q - $past(setpoint_q) <= $past(step_up) &&
        setpoint_q <= $past(target)) // [R06] [R13]
    else $error("rise step wrong or overshoot");

  a_fall_step: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && tick_q && !prop && setpoint_q > target
    |=> setpoint_q < $past(setpoint_q) &&
        $past(setpoint_q) - setpoint_q <= $past(step_dn) &&
        setpoint_q >= $past(target)) // [R07] [R11] [R13]
    else $error("fall step wrong or undershoot");

  a_onoff_rise: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && !prop && tick_q && target == cur_max_q && setpoint_q < target
    |=> setpoint_q == (($past(setpoint_q) > $past(target) - $past(step_up)) ?
        $past(target) : $past(setpoint_q) + $past(step_up))) // [R10]
    else $error("on/off rise increment wrong");

  a_prop_fall: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && tick_q && prop && !jump && target != '0 && setpoint_q > target
    |=> setpoint_q < $past(setpoint_q) &&
        $past(setpoint_q) - setpoint_q <= $past(step_dn) &&
        setpoint_q >= $past(target)) // [R05] [R07] [R13]
    else $error("proportional fall step wrong or undershoot");

  a_prop_release: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && tick_q && prop && target == '0 && setpoint_q > cur_min_q
    |=> setpoint_q < $past(setpoint_q) &&
        setpoint_q >= $past(cur_min_q)) // [R09]
    else $error("release ramp passed below minimum");

  a_prop_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && prop && !tick_q && !jump &&
    !(target == '0 && setpoint_q <= cur_min_q)
    |=> $stable(setpoint_q)) // [R05]
    else $error("set-point moved between proportional ticks");

  a_map_range: assert property (@(posedge hclk) disable iff (!hresetn)
    prop && en_q && pot_s_q >= pot_min_q && pot_s_q < pot_max_q &&
    cur_max_q >= cur_min_q
    |-> target >= cur_min_q && target <= cur_max_q) // [R02]
    else $error("mapped target outside current limits");

  a_off_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    !en_q |-> target == '0)
    else $error("target not zero while disabled");

  a_bus_ready: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && take |=> !hreadyout ##1 (hreadyout || !$past(ce)))
    else $error("slave wait state not one cycle");

endmodule : vcsr_top

// *** tb/vcsr_lower_pot_model.sv ***
// Lowering potentiometer and request switch seen by the set-point block
module vcsr_lower_pot_model (
  input  wire logic        hclk,
  input  wire logic [11:0] pot_code,
  input  wire logic        req_level,
  output logic      [11:0] pot_voltage,
  output logic             lower_req
);
  timeunit 1ns;
  timeprecision 1ns;

  // Pins move just after a clock edge, held until the next command
  always_ff @(posedge hclk) begin
    pot_voltage <= pot_code;
    lower_req   <= req_level;
  end
endmodule : vcsr_lower_pot_model

// *** tb/tb_vcsr_top.sv ***
// Self-checking bench of the valve current set-point block
`include "vcsr_defs.svh"

module tb_vcsr_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TICK = 4;

  logic        hclk;
  logic        hresetn;
  logic        ce;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [11:0] pot_voltage;
  logic [11:0] pot_cmd;
  logic        lower_req;
  logic        req_cmd;
  logic [15:0] valve_setpoint;
  logic        valve_active;
  logic [31:0] rd;
  logic [15:0] chg[$];
  int          stamp[$];
  logic [15:0] sp_last;
  int          cyc;
  int          mismatches;
  int          cmp_count;
  logic [31:0] rst [8] = '{32'h0, 32'(`VCSR_RST_POT_MIN),
    32'(`VCSR_RST_POT_MAX), 32'(`VCSR_RST_CUR_MIN), 32'(`VCSR_RST_CUR_MAX),
    32'(`VCSR_RST_RISE), 32'(`VCSR_RST_FALL), 32'h0};

  vcsr_top #(.TICK_CYCLES(TICK)) u_vcsr_top (
    .hclk           (hclk),
    .hresetn        (hresetn),
    .ce             (ce),
    .hsel           (hsel),
    .haddr          (haddr),
    .htrans         (htrans),
    .hwrite         (hwrite),
    .hsize          (hsize),
    .hwdata         (hwdata),
    .hready         (hreadyout),
    .hrdata         (hrdata),
    .hreadyout      (hreadyout),
    .hresp          (hresp),
    .pot_voltage    (pot_voltage),
    .lower_req      (lower_req),
    .valve_setpoint (valve_setpoint),
    .valve_active   (valve_active)
  );

  vcsr_lower_pot_model u_vcsr_lower_pot_model (
    .hclk        (hclk),
    .pot_code    (pot_cmd),
    .req_level   (req_cmd),
    .pot_voltage (pot_voltage),
    .lower_req   (lower_req)
  );

  always #5 hclk = ~hclk;

  ////////////////////////////////////////////////////////////////////////////
  // Set-point change log and hang guard
  always @(posedge hclk) begin
    cyc++;
    if (hresetn === 1'b1 && valve_setpoint !== sp_last) begin
      chg.push_back(valve_setpoint);
      stamp.push_back(cyc);
    end
    sp_last = valve_setpoint;
    if (cyc == 20000) begin
      mismatches++;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus and check tasks
  task automatic wait_ready();
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
  endtask : wait_ready

  task automatic ahb_xfer(input logic [7:0] a, input logic w,
                          input logic [31:0] d, output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
    q = hrdata;
    check("hresp okay", {31'h0, hresp}, 32'h0);
  endtask : ahb_xfer

  task automatic ahb_write(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb_xfer(a, 1'b1, d, q);
  endtask : ahb_write

  task automatic ahb_read(input logic [7:0] a, output logic [31:0] q);
    ahb_xfer(a, 1'b0, 32'h0, q);
  endtask : ahb_read

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic settle(input logic [15:0] v);
    while (valve_setpoint !== v) begin
      @(posedge hclk);
    end
    repeat (3 * TICK) @(posedge hclk);
  endtask : settle

  // Logged values, tick gaps for steps g0..g1-1, one-cycle gaps after
  task automatic check_seq(input string what, input logic [15:0] e [5],
                           input int n, input int g0, input int g1);
    check({what, " count"}, 32'(chg.size()), 32'(n));
    for (int i = 0; i < n && i < chg.size(); i++) begin
      check(what, {16'h0, chg[i]}, {16'h0, e[i]});
    end
    for (int i = g0; i < n && i < stamp.size(); i++) begin
      check({what, " gap"}, 32'(stamp[i] - stamp[i-1]),
            32'((i < g1) ? TICK : 1));
    end
    chg.delete();
    stamp.delete();
    $display("test %s done", what);
  endtask : check_seq

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    hclk    = 1'b0;
    hresetn = 1'b0;
    ce      = 1'b1;
    hsel    = 1'b0;
    haddr   = 32'h0;
    htrans  = 2'b00;
    hwrite  = 1'b0;
    hsize   = 3'b010;
    hwdata  = 32'h0;
    pot_cmd = 12'h000;
    req_cmd = 1'b0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 8; i++) begin
      ahb_read(8'(i * 4), rd);
      check("reset value", rd, rst[i]);
    end
    ahb_read(8'h40, rd);
    check("unmapped read", rd, 32'h0);
    $display("test registers done");
    ahb_write(`VCSR_OFF_CUR_MAX, 32'h500);
    ahb_write(`VCSR_OFF_CUR_MIN, 32'h300);
    ahb_write(`VCSR_OFF_RISE, 32'h3);
    ahb_write(`VCSR_OFF_FALL, 32'h4);
    ahb_read(`VCSR_OFF_CUR_MAX, rd);
    check("cur max readback", rd, 32'h500);
    // On/off: no jump to the minimum, last step clamped
    ahb_write(`VCSR_OFF_CTRL, 32'h3);
    chg.delete();
    stamp.delete();
    req_cmd <= 1'b1;
    settle(16'h500);
    check("active on", {31'h0, valve_active}, 32'h1);
    check_seq("onoff rise", '{16'h1aa, 16'h354, 16'h4fe, 16'h500, 16'h0},
              4, 1, 4);
    req_cmd <= 1'b0;
    settle(16'h0);
    check("active off", {31'h0, valve_active}, 32'h0);
    check_seq("onoff fall", '{16'h3c0, 16'h280, 16'h140, 16'h0, 16'h0},
              4, 1, 4);
    // Proportional: jump to minimum, map, saturation, release
    ahb_write(`VCSR_OFF_CUR_MIN, 32'h100);
    ahb_write(`VCSR_OFF_RISE, 32'h4);
    ahb_write(`VCSR_OFF_CTRL, 32'h2);
    pot_cmd <= 12'hfff;
    settle(16'h500);
    check_seq("prop step", '{16'h100, 16'h200, 16'h300, 16'h400, 16'h500},
              5, 2, 5);
    pot_cmd <= 12'h780;
    settle(16'h300);
    check_seq("prop mid", '{16'h400, 16'h300, 16'h0, 16'h0, 16'h0},
              2, 1, 2);
    ahb_read(`VCSR_OFF_STATUS, rd);
    check("status mid", rd, 32'h0001_0300);
    // Clock enable low freezes sync, tick and set-point
    pot_cmd <= 12'h080;
    ce      <= 1'b0;
    repeat (3 * TICK) @(posedge hclk);
    check("frozen", {16'h0, valve_setpoint}, 32'h300);
    ce      <= 1'b1;
    settle(16'h0);
    check_seq("prop release", '{16'h200, 16'h100, 16'h0, 16'h0, 16'h0},
              3, 1, 2);
    end_of_test();
  end
endmodule : tb_vcsr_top
